// File: pkg/pipe_lane_regs.vh
`ifndef PIPE_LANE_REGS_VH
`define PIPE_LANE_REGS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define RATE_SW_NS 1000
`define RATE_SW_CYC ((`RATE_SW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RX_IDLE_NS 512
`define RX_IDLE_CYC (`RX_IDLE_NS / `CLK_PERIOD_NS)

// ----------------------------------------
// rate select codes
// ----------------------------------------
`define RATE_GEN1 2'h0
`define RATE_GEN2 2'h1

// ----------------------------------------
// power states
// ----------------------------------------
`define PWR_P0 2'h0
`define PWR_P0S 2'h1
`define PWR_P1 2'h2
`define PWR_P2 2'h3

// ----------------------------------------
// receive status codes
// ----------------------------------------
`define RXST_OK 3'h0
`define RXST_SKP_ADD 3'h1
`define RXST_SKP_DEL 3'h2
`define RXST_RX_PRESENT 3'h3
`define RXST_OVERFLOW 3'h5
`define RXST_UNDERFLOW 3'h6

// ----------------------------------------
// symbols, {k, byte}
// ----------------------------------------
`define SYM_COM 9'h1_BC
`define SYM_SKP 9'h1_1C
`define SYM_EDB 9'h1_FE

// ----------------------------------------
// fifo layout: {ins_mark, status[2:0], sym[8:0]}
// ----------------------------------------
`define RM_SYM_W 9
`define RM_ST_LSB 9
`define RM_INS_BIT 12
`define RM_ENTRY_W 13
`define RM_AW 4
`define RM_LOW_MARK 4
`define RM_HIGH_MARK 12

// ----------------------------------------
// compliance pattern, 10-bit coded words
// ----------------------------------------
`define CPAT_0 10'h0_FA
`define CPAT_1 10'h2_AA
`define CPAT_2 10'h3_05
`define CPAT_3 10'h1_55
`define PAR_W 10

`endif

// File: rtl/rm_fifo_mem.v
// ----------------------------------------
// storage with registered read and write forwarding
// ----------------------------------------
module rm_fifo_mem #(
	parameter W = 13,
	parameter AW = 4
) (
	// clock
	input wire mclk_in,
	// write side
	input wire wr_en_in,
	input wire [AW-1:0] wr_addr_in,
	input wire [W-1:0] wr_data_in,
	// read side
	input wire [AW-1:0] rd_addr_in,
	output reg [W-1:0] rd_data_out
);
	reg [W-1:0] mem [0:(1<<AW)-1];

	always @(posedge mclk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	// same-cycle write to the addressed word is passed through
	always @(posedge mclk_in) begin
		if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
			rd_data_out <= wr_data_in;
		end else begin
			rd_data_out <= mem[rd_addr_in];
		end
	end
endmodule // rm_fifo_mem

// File: rtl/two_entry_buf.v
// ----------------------------------------
// two-entry buffer, registered outputs
// ----------------------------------------
module two_entry_buf #(
	parameter W = 12
) (
	// clock and reset
	input wire mclk_in,
	input wire rst_in,
	// fill side
	input wire in_valid_in,
	input wire [W-1:0] in_data_in,
	output reg in_ready_out,
	// drain side
	output reg out_valid_out,
	output reg [W-1:0] out_data_out,
	input wire out_ready_in
);
	reg [W-1:0] spare_r;
	reg spare_vld_r;
	wire push = in_valid_in && in_ready_out;
	wire pull = out_valid_out && out_ready_in;

	always @(posedge mclk_in) begin
		if (rst_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= {W{1'b0}};
			spare_r <= {W{1'b0}};
			spare_vld_r <= 1'b0;
			in_ready_out <= 1'b1;
		end else begin
			if (!out_valid_out || pull) begin
				if (spare_vld_r) begin
					out_data_out <= spare_r;
					out_valid_out <= 1'b1;
					spare_vld_r <= push;
					spare_r <= in_data_in;
					in_ready_out <= 1'b1;
				end else begin
					out_data_out <= in_data_in;
					out_valid_out <= push;
					in_ready_out <= 1'b1;
				end
			end else if (push) begin
				// head stalled: word parks in the spare slot
				spare_r <= in_data_in;
				spare_vld_r <= 1'b1;
				in_ready_out <= 1'b0;
			end
		end
	end
endmodule // two_entry_buf

// File: rtl/pipe_lane.v
`include "pipe_lane_regs.vh"

module pipe_lane #(
	parameter AW = `RM_AW,
	parameter LOW_MARK = `RM_LOW_MARK,
	parameter HIGH_MARK = `RM_HIGH_MARK,
	parameter RATE_SW_CYC = `RATE_SW_CYC,
	parameter RX_IDLE_CYC = `RX_IDLE_CYC
) (
	// clock and reset
	input wire mclk_in,
	input wire rst_in,
	// MAC control
	input wire [1:0] rate_in,
	input wire [1:0] powerdown_in,
	input wire tx_elecidle_in,
	input wire detect_req_in,
	input wire compliance_in,
	input wire zero_ppm_in,
	// transmit coded data
	input wire [`PAR_W-1:0] tx_code_in,
	output reg [`PAR_W-1:0] tx_par_out,
	output reg tx_elecidle_out,
	// PMA control
	output reg [1:0] rate_sel_out,
	output reg rxdet_cmd_out,
	input wire rxdet_done_in,
	input wire rxdet_present_in,
	// receive symbols from decoder
	input wire rx_valid_in,
	input wire [8:0] rx_sym_in,
	// receive to MAC
	output reg rx_valid_out,
	output reg [8:0] rx_data_out,
	output reg [2:0] rx_status_out,
	input wire rx_ready_in,
	output reg phy_status_out,
	output reg receive_idle_inference_out
);
	localparam CW = AW + 1;
	localparam [CW-1:0] DEPTH = 1 << AW;
	localparam [CW-1:0] LOW_C = LOW_MARK;
	localparam [CW-1:0] HIGH_C = HIGH_MARK;
	localparam [15:0] RSW_LAST = RATE_SW_CYC - 1;
	localparam [15:0] IDLE_LAST = RX_IDLE_CYC - 1;
	localparam BW = `RM_ENTRY_W - 1;

	// ----------------------------------------
	// rate switching
	// ----------------------------------------
	reg sw_busy_r;
	reg [15:0] sw_cnt_r;
	reg sw_done_r;
	wire rate_legal = (rate_in == `RATE_GEN1) || (rate_in == `RATE_GEN2);

	always @(posedge mclk_in) begin
		if (rst_in) begin
			rate_sel_out <= `RATE_GEN1;
			sw_busy_r <= 1'b0;
			sw_cnt_r <= 16'h0000;
			sw_done_r <= 1'b0;
		end else begin
			sw_done_r <= 1'b0;
			if (sw_busy_r) begin
				if (sw_cnt_r == 16'h0000) begin
					sw_busy_r <= 1'b0;
					sw_done_r <= 1'b1;
				end else begin
					sw_cnt_r <= sw_cnt_r - 16'h0001;
				end
			end else if (rate_legal && (rate_in != rate_sel_out)) begin
				rate_sel_out <= rate_in;
				sw_busy_r <= 1'b1;
				sw_cnt_r <= RSW_LAST;
			end
		end
	end

	// ----------------------------------------
	// power state and receiver detect
	// ----------------------------------------
	reg [1:0] pwr_r;
	reg pwr_chg_r;
	reg det_req_d_r;
	reg det_done_r;
	reg det_found_r;

	always @(posedge mclk_in) begin
		if (rst_in) begin
			pwr_r <= `PWR_P1;
			pwr_chg_r <= 1'b0;
			det_req_d_r <= 1'b0;
			rxdet_cmd_out <= 1'b0;
			det_done_r <= 1'b0;
			det_found_r <= 1'b0;
		end else begin
			pwr_r <= powerdown_in;
			pwr_chg_r <= (powerdown_in != pwr_r);
			det_req_d_r <= detect_req_in;
			det_done_r <= 1'b0;
			if (rxdet_cmd_out) begin
				if (rxdet_done_in) begin
					rxdet_cmd_out <= 1'b0;
					det_done_r <= 1'b1;
					det_found_r <= rxdet_present_in;
				end
			end else if (detect_req_in && !det_req_d_r && (pwr_r == `PWR_P1)) begin
				rxdet_cmd_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// transmit path
	// ----------------------------------------
	reg [1:0] cpat_idx_r;
	reg [`PAR_W-1:0] cpat_word;

	always @* begin
		case (cpat_idx_r)
			2'h0: cpat_word = `CPAT_0;
			2'h1: cpat_word = `CPAT_1;
			2'h2: cpat_word = `CPAT_2;
			default: cpat_word = `CPAT_3;
		endcase
	end

	always @(posedge mclk_in) begin
		if (rst_in) begin
			tx_par_out <= {`PAR_W{1'b0}};
			tx_elecidle_out <= 1'b1;
			cpat_idx_r <= 2'h0;
		end else begin
			// idle on request or any low power state
			tx_elecidle_out <= tx_elecidle_in || (powerdown_in != `PWR_P0);
			if (compliance_in) begin
				cpat_idx_r <= cpat_idx_r + 2'h1;
				tx_par_out <= cpat_word;
			end else begin
				cpat_idx_r <= 2'h0;
				tx_par_out <= tx_code_in;
			end
		end
	end

	// ----------------------------------------
	// rate match fifo, write side
	// ----------------------------------------
	reg [CW-1:0] cnt_r;
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg del_arm_r;
	reg full_pend_r;
	reg [2:0] wr_tag;
	wire wr_com = (rx_sym_in == `SYM_COM);
	wire wr_skp = (rx_sym_in == `SYM_SKP);
	wire full = (cnt_r == DEPTH);
	// remove the one skip after a marked COM
	wire del_drop = rx_valid_in && del_arm_r && wr_skp;
	wire wr_en = rx_valid_in && !full && !del_drop;
	wire overflow = rx_valid_in && full && !del_drop;
	wire [`RM_ENTRY_W-1:0] wr_word;

	always @* begin
		wr_tag = `RXST_OK;
		// overflow flag on the next stored byte
		if (full_pend_r) begin
			wr_tag = `RXST_OVERFLOW;
		// no compensation in 0 ppm mode
		end else if (wr_com && !zero_ppm_in) begin
			if (cnt_r < LOW_C) begin
				wr_tag = `RXST_SKP_ADD;
			end else if (cnt_r >= HIGH_C) begin
				wr_tag = `RXST_SKP_DEL;
			end
		end
	end

	assign wr_word = {(wr_tag == `RXST_SKP_ADD), wr_tag, rx_sym_in};

	always @(posedge mclk_in) begin
		if (rst_in) begin
			wr_ptr_r <= {AW{1'b0}};
			del_arm_r <= 1'b0;
			full_pend_r <= 1'b0;
		end else begin
			if (wr_en) begin
				wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (rx_valid_in) begin
				del_arm_r <= wr_en && (wr_tag == `RXST_SKP_DEL);
			end
			if (overflow) begin
				full_pend_r <= 1'b1;
			end else if (wr_en) begin
				full_pend_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// rate match fifo, read side
	// ----------------------------------------
	reg ins_pend_r;
	reg edb_pend_r;
	reg [BW-1:0] push_word;
	wire [`RM_ENTRY_W-1:0] head;
	wire buf_ready;
	wire have = (cnt_r != {CW{1'b0}});
	wire gen_pend = ins_pend_r || edb_pend_r;
	wire push = buf_ready && (gen_pend || have);
	wire pop = buf_ready && !gen_pend && have;
	wire [AW-1:0] rd_ptr_nxt = rd_ptr_r + {{(AW-1){1'b0}}, pop};
	wire [CW-1:0] cnt_nxt = cnt_r + {{(CW-1){1'b0}}, wr_en} - {{(CW-1){1'b0}}, pop};

	always @* begin
		if (ins_pend_r) begin
			push_word = {`RXST_OK, `SYM_SKP};
		end else if (edb_pend_r) begin
			push_word = {`RXST_UNDERFLOW, `SYM_EDB};
		end else begin
			push_word = head[BW-1:0];
		end
	end

	always @(posedge mclk_in) begin
		if (rst_in) begin
			cnt_r <= {CW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			ins_pend_r <= 1'b0;
			edb_pend_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			// one skip follows a marked COM
			if (pop && head[`RM_INS_BIT]) begin
				ins_pend_r <= 1'b1;
			end else if (buf_ready) begin
				ins_pend_r <= 1'b0;
			end
			if (pop && (cnt_r == {{(CW-1){1'b0}}, 1'b1}) && !wr_en) begin
				edb_pend_r <= 1'b1;
			end else if (buf_ready && !ins_pend_r) begin
				edb_pend_r <= 1'b0;
			end
		end
	end

	rm_fifo_mem #(
		.W(`RM_ENTRY_W),
		.AW(AW)
	) u_mem (
		.mclk_in(mclk_in),
		.wr_en_in(wr_en),
		.wr_addr_in(wr_ptr_r),
		.wr_data_in(wr_word),
		.rd_addr_in(rd_ptr_nxt),
		.rd_data_out(head)
	);

	// ----------------------------------------
	// output buffer and MAC-facing registers
	// ----------------------------------------
	wire buf_vld;
	wire [BW-1:0] buf_word;
	wire out_load = !rx_valid_out || rx_ready_in;

	two_entry_buf #(
		.W(BW)
	) u_buf (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.in_valid_in(push),
		.in_data_in(push_word),
		.in_ready_out(buf_ready),
		.out_valid_out(buf_vld),
		.out_data_out(buf_word),
		.out_ready_in(out_load)
	);

	always @(posedge mclk_in) begin
		if (rst_in) begin
			rx_valid_out <= 1'b0;
			rx_data_out <= 9'h000;
			rx_status_out <= `RXST_OK;
			phy_status_out <= 1'b0;
		end else begin
			phy_status_out <= sw_done_r || pwr_chg_r || det_done_r;
			if (out_load) begin
				rx_valid_out <= buf_vld;
				rx_data_out <= buf_word[8:0];
			end
			if (det_done_r) begin
				rx_status_out <= det_found_r ? `RXST_RX_PRESENT : `RXST_OK;
			// fifo flag travels with its symbol
			end else if (out_load) begin
				rx_status_out <= buf_vld ? buf_word[BW-1:`RM_ST_LSB] : `RXST_OK;
			end
		end
	end

	// ----------------------------------------
	// receive idle inference
	// ----------------------------------------
	reg [15:0] idle_cnt_r;

	always @(posedge mclk_in) begin
		if (rst_in) begin
			idle_cnt_r <= 16'h0000;
			receive_idle_inference_out <= 1'b0;
		end else if (rx_valid_in) begin
			idle_cnt_r <= 16'h0000;
			receive_idle_inference_out <= 1'b0;
		end else if (idle_cnt_r == IDLE_LAST) begin
			receive_idle_inference_out <= 1'b1;
		end else begin
			idle_cnt_r <= idle_cnt_r + 16'h0001;
		end
	end
endmodule // pipe_lane

// File: bench/pipe_lane_sva.sv
module pipe_lane_sva (
	// clock and reset
	input wire mclk_in,
	input wire rst_in,
	// control inputs
	input wire [1:0] rate_in,
	input wire [1:0] powerdown_in,
	input wire tx_elecidle_in,
	input wire compliance_in,
	input wire rxdet_done_in,
	input wire rxdet_present_in,
	input wire rx_ready_in,
	// observed outputs
	input wire [9:0] tx_par_out,
	input wire tx_elecidle_out,
	input wire [1:0] rate_sel_out,
	input wire rxdet_cmd_out,
	input wire rx_valid_out,
	input wire [8:0] rx_data_out,
	input wire [2:0] rx_status_out,
	input wire phy_status_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	idle_request_a: assert property (tx_elecidle_in |=> tx_elecidle_out)
		else $error("tx idle not forced");
	p1_idle_a: assert property (powerdown_in == 2'h2 |=> tx_elecidle_out)
		else $error("tx active in P1");
	only_idle_saving_a: assert property (!tx_elecidle_in && powerdown_in == 2'h0 |=> !tx_elecidle_out)
		else $error("tx idle in P0");
	rate_follow_a: assert property ($changed(rate_sel_out) |-> rate_sel_out == $past(rate_in))
		else $error("rate select not requested");
	detect_hold_a: assert property (rxdet_cmd_out && !rxdet_done_in |=> rxdet_cmd_out)
		else $error("detect command dropped early");
	detect_result_a: assert property (rxdet_cmd_out && rxdet_done_in |-> ##2 phy_status_out
		&& rx_status_out == ($past(rxdet_present_in, 2) ? 3'h3 : 3'h0))
		else $error("detect result wrong");
	status_pulse_a: assert property (phy_status_out |=> !phy_status_out)
		else $error("status pulse too long");
	compliance_start_a: assert property ($rose(compliance_in) |=> tx_par_out == 10'h0FA)
		else $error("compliance pattern start wrong");
	stall_hold_a: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out
		&& $stable(rx_data_out) && $stable(rx_status_out))
		else $error("word lost under stall");
	edb_status_a: assert property (rx_valid_out && rx_data_out == 9'h1FE |-> rx_status_out == 3'h6)
		else $error("inserted symbol status wrong");
	reset_state_a: assert property (disable iff (1'b0) rst_in |=> !rx_valid_out
		&& rate_sel_out == 2'h0 && rx_status_out == 3'h0)
		else $error("reset state wrong");

	cover property (rxdet_cmd_out && rxdet_done_in);
	cover property (rx_valid_out && rx_status_out == 3'h5);
	cover property ($rose(rate_sel_out[0]));
endmodule // pipe_lane_sva

bind pipe_lane pipe_lane_sva i_sva (.mclk_in(mclk_in), .rst_in(rst_in), .rate_in(rate_in),
	.powerdown_in(powerdown_in), .tx_elecidle_in(tx_elecidle_in), .compliance_in(compliance_in),
	.rxdet_done_in(rxdet_done_in), .rxdet_present_in(rxdet_present_in), .rx_ready_in(rx_ready_in),
	.tx_par_out(tx_par_out), .tx_elecidle_out(tx_elecidle_out), .rate_sel_out(rate_sel_out),
	.rxdet_cmd_out(rxdet_cmd_out), .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out),
	.rx_status_out(rx_status_out), .phy_status_out(phy_status_out));

// File: bench/mac_rx_model.sv
// ----------------------------------------
// receive sink, stalls on request
// ----------------------------------------
module mac_rx_model (
	// clock
	input wire mclk_in,
	// stall control
	input wire stall_in,
	// receive words
	input wire valid_in,
	input wire [8:0] data_in,
	input wire [2:0] status_in,
	output logic ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] got[$];
	initial ready_out = 1'b0;
	always @(posedge mclk_in) begin
		if (valid_in && ready_out)
			got.push_back({status_in, data_in});
		ready_out <= !stall_in;
	end
endmodule // mac_rx_model

// File: bench/tb.sv
`include "pipe_lane_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SW = 4;
	logic mclk_in = 0, rst_in = 1, tx_elecidle_in = 0, detect_req_in = 0, compliance_in = 0;
	logic zero_ppm_in = 0, rxdet_done_in = 0, rxdet_present_in = 0, rx_valid_in = 0, stall = 0;
	logic [1:0] rate_in = 0, powerdown_in = 0;
	logic [8:0] rx_sym_in = 0;
	logic [9:0] tx_code_in = 10'h155;
	wire [9:0] tx_par_out;
	wire [1:0] rate_sel_out;
	wire [8:0] rx_data_out;
	wire [2:0] rx_status_out;
	wire tx_elecidle_out, rxdet_cmd_out, rx_valid_out, rx_ready_in, phy_status_out, idle_inf;
	logic [9:0] cpat[4] = '{`CPAT_0, `CPAT_1, `CPAT_2, `CPAT_3};
	int miscompares = 0, checked = 0, cycles = 0, n, skp;
	logic [2:0] cst;
	logic ovf, edb;

	always #2 mclk_in = ~mclk_in;

	pipe_lane #(.RATE_SW_CYC(SW), .RX_IDLE_CYC(8)) i_pipe_lane (.mclk_in(mclk_in), .rst_in(rst_in),
		.rate_in(rate_in), .powerdown_in(powerdown_in), .tx_elecidle_in(tx_elecidle_in),
		.detect_req_in(detect_req_in), .compliance_in(compliance_in), .zero_ppm_in(zero_ppm_in),
		.tx_code_in(tx_code_in), .tx_par_out(tx_par_out), .tx_elecidle_out(tx_elecidle_out),
		.rate_sel_out(rate_sel_out), .rxdet_cmd_out(rxdet_cmd_out), .rxdet_done_in(rxdet_done_in),
		.rxdet_present_in(rxdet_present_in), .rx_valid_in(rx_valid_in), .rx_sym_in(rx_sym_in),
		.rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out), .rx_status_out(rx_status_out),
		.rx_ready_in(rx_ready_in), .phy_status_out(phy_status_out), .receive_idle_inference_out(idle_inf));
	mac_rx_model i_mac_rx_model (.mclk_in(mclk_in), .stall_in(stall), .valid_in(rx_valid_out),
		.data_in(rx_data_out), .status_in(rx_status_out), .ready_out(rx_ready_in));

	task wrap_up;
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(string nm, logic [11:0] e, logic [11:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task wait_phy(int lim);
		n = 0;
		do begin
			@(posedge mclk_in);
			#1;
			n++;
		end while (phy_status_out !== 1'b1 && n < lim);
	endtask
	task send(logic [8:0] s);
		@(negedge mclk_in);
		rx_valid_in = 1;
		rx_sym_in = s;
	endtask
	task idle(int c);
		@(negedge mclk_in);
		rx_valid_in = 0;
		repeat (c) @(negedge mclk_in);
	endtask
	task scan;
		skp = 0;
		cst = 3'h7;
		ovf = 0;
		edb = 0;
		foreach (i_mac_rx_model.got[k]) begin
			if (i_mac_rx_model.got[k][8:0] === 9'h11C) skp++;
			if (i_mac_rx_model.got[k][8:0] === 9'h1BC) cst = i_mac_rx_model.got[k][11:9];
			if (i_mac_rx_model.got[k][11:9] === 3'h5) ovf = 1;
			if (i_mac_rx_model.got[k] === 12'hDFE) edb = 1;
		end
		i_mac_rx_model.got.delete();
	endtask

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		repeat (3) @(negedge mclk_in);
		rst_in = 0;
		chk("rate", 0, rate_sel_out);
		chk("valid", 0, rx_valid_out);
		wait_phy(10);
		chk("reset pwr", 1, phy_status_out);
		for (int p = 3; p >= 0; p--) begin
			@(negedge mclk_in);
			powerdown_in = p[1:0];
			wait_phy(20);
			chk("pwr done", 1, phy_status_out);
			chk("pwr time", 2, n);
			chk("tx idle", p != 0, tx_elecidle_out);
		end
		@(negedge mclk_in);
		tx_elecidle_in = 1;
		repeat (2) @(negedge mclk_in);
		chk("idle req", 1, tx_elecidle_out);
		tx_elecidle_in = 0;
		for (int r = 1; r >= 0; r--) begin
			@(negedge mclk_in);
			rate_in = r[1:0];
			repeat (2) @(negedge mclk_in);
			chk("rate sel", r, rate_sel_out);
			wait_phy(40);
			chk("rate time", SW, n);
		end
		@(negedge mclk_in);
		compliance_in = 1;
		@(negedge mclk_in);
		foreach (cpat[k]) begin
			chk("cpat", cpat[k], tx_par_out);
			@(negedge mclk_in);
		end
		compliance_in = 0;
		powerdown_in = 2'h2;
		wait_phy(20);
		chk("tx data", 10'h155, tx_par_out);
		@(negedge mclk_in);
		detect_req_in = 1;
		repeat (2) @(negedge mclk_in);
		chk("det cmd", 1, rxdet_cmd_out);
		rxdet_present_in = 1;
		rxdet_done_in = 1;
		@(negedge mclk_in);
		rxdet_done_in = 0;
		wait_phy(10);
		chk("det status", 3, rx_status_out);
		detect_req_in = 0;
		@(negedge mclk_in);
		powerdown_in = 2'h0;
		chk("idle inf", 1, idle_inf);
		for (int k = 1; k < 5; k++) send(k[8:0]);
		chk("idle clr", 0, idle_inf);
		idle(20);
		chk("rx first", 12'h001, i_mac_rx_model.got[0]);
		scan();
		chk("empty edb", 1, edb);
		for (int z = 0; z < 2; z++) begin
			zero_ppm_in = z[0];
			send(9'h1BC);
			send(9'h11C);
			send(9'h11C);
			send(9'h005);
			idle(20);
			scan();
			chk("add flag", z ? 0 : 1, cst);
			chk("add skp", z ? 2 : 3, skp);
		end
		zero_ppm_in = 0;
		stall = 1;
		for (int k = 0; k < 15; k++) send(9'h010);
		send(9'h1BC);
		send(9'h11C);
		idle(5);
		stall = 0;
		idle(40);
		scan();
		chk("del flag", 2, cst);
		chk("del skp", 0, skp);
		stall = 1;
		for (int k = 0; k < 24; k++) send(9'h020);
		idle(5);
		stall = 0;
		idle(5);
		send(9'h031);
		idle(50);
		chk("ovf count", 21, i_mac_rx_model.got.size());
		scan();
		chk("overflow", 1, ovf);
		wrap_up();
	end
endmodule // tb
